// ===== hdl/itm_pkg.sv
// package of constants for the instruction timing sequencer
// assumes a single 50 MHz core clock and synchronous reset
package itm_pkg;
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned STATES_PER_MC  = 4;
  localparam logic [7:0]  RESET_OPCODE   = 8'h00;
  localparam logic [2:0]  LEN_ONE        = 3'h1;
  localparam logic [2:0]  LEN_TWO        = 3'h2;
  localparam logic [2:0]  LEN_THREE      = 3'h3;
  localparam logic [2:0]  CYC_FIVE       = 3'h5;
  localparam logic [2:0]  CYC_EXTRA_JUMP = 3'h1;
  localparam logic [7:0]  OP_NOP         = 8'h00;
  localparam logic [7:0]  OP_INC_DP      = 8'hA3;
  localparam logic [7:0]  OP_MUL         = 8'hA4;
  localparam logic [7:0]  OP_DIV         = 8'h84;
  localparam logic [7:0]  OP_CLR_A       = 8'hE4;
  localparam logic [7:0]  OP_MOV_A_IMM   = 8'h74;
  localparam logic [7:0]  OP_MOV_IND_A   = 8'hF6;
  localparam logic [7:0]  OP_MOV_IND1_A  = 8'hF7;
  // machine-cycle state, gray coded along C1..C4
  typedef enum logic [1:0] {
    ST_C1 = 2'h0,
    ST_C2 = 2'h1,
    ST_C3 = 2'h3,
    ST_C4 = 2'h2
  } phase_t;
endpackage

// ===== hdl/itm_phase.sv
// four-state machine-cycle sequencer
// assumes CLK is the core clock and SRST a synchronous reset
`timescale 1ns/10ps
module itm_phase (
  input  wire logic            clk,        // core clock
  input  wire logic            srst,       // synchronous reset
  output itm_pkg::phase_t      phase,      // current state
  output      logic            mc_end      // last state of a machine cycle
);
  typedef struct packed {
    itm_pkg::phase_t ph;
  } st_t;
  st_t state_reg;
  st_t state_next;

  ////////////////////////////////////////////////////////////////////////
  // fixed order C1 -> C4, one clock each
  always_comb begin
    state_next = state_reg;
    case (state_reg.ph)
      itm_pkg::ST_C1: state_next.ph = itm_pkg::ST_C2;
      itm_pkg::ST_C2: state_next.ph = itm_pkg::ST_C3;
      itm_pkg::ST_C3: state_next.ph = itm_pkg::ST_C4;
      itm_pkg::ST_C4: state_next.ph = itm_pkg::ST_C1;
      default:        state_next.ph = itm_pkg::ST_C1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg.ph <= itm_pkg::ST_C1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign phase  = state_reg.ph;
  assign mc_end = (state_reg.ph == itm_pkg::ST_C4);

  chk_phase_order: assert property (@(posedge clk) disable iff (srst)
    (phase == itm_pkg::ST_C1) |=> (phase == itm_pkg::ST_C2) ##1 (phase == itm_pkg::ST_C3)
      ##1 (phase == itm_pkg::ST_C4) ##1 (phase == itm_pkg::ST_C1))
    else $error("machine cycle states out of order");
endmodule

// ===== hdl/itm_decode.sv
// opcode decoder: byte length and machine-cycle count
// assumes a byte from program memory; pure combinational
`timescale 1ns/10ps
module itm_decode (
  input  wire logic [7:0] opcode,   // first instruction byte
  output      logic [2:0] len,      // instruction length in bytes
  output      logic [2:0] cycles,   // machine cycles to execute
  output      logic       known     // opcode is decoded here
);
  ////////////////////////////////////////////////////////////////////////
  // table of lengths; cycles follow bytes unless noted
  always_comb begin
    len    = itm_pkg::LEN_ONE;
    known  = 1'b1;
    casez (opcode)
      8'h00, 8'h04, 8'h14, 8'hD4, 8'hE4, 8'hF4, 8'h23, 8'h33,
      8'h03, 8'h13, 8'hC4, 8'hF6, 8'hF7:     len = itm_pkg::LEN_ONE;
      8'b0000_1???, 8'b0000_011?,
      8'b0001_1???, 8'b0001_011?,
      8'b0010_1???, 8'b0010_011?,
      8'b0011_1???, 8'b0011_011?,
      8'b0100_1???, 8'b0100_011?,
      8'b0101_1???, 8'b0101_011?,
      8'b0110_1???, 8'b0110_011?,
      8'b1001_1???, 8'b1001_011?,
      8'b1110_1???, 8'b1110_011?,
      8'b1111_1???:                         len = itm_pkg::LEN_ONE;
      8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95, 8'h05, 8'h15,
      8'h42, 8'h44, 8'h45, 8'h52, 8'h54, 8'h55, 8'h62, 8'h64,
      8'h65, 8'hE5, 8'h74:                  len = itm_pkg::LEN_TWO;
      8'b1010_1???, 8'b0111_1???:            len = itm_pkg::LEN_TWO;
      8'h43, 8'h53, 8'h63:                   len = itm_pkg::LEN_THREE;
      8'hA3, 8'hA4, 8'h84:                   len = itm_pkg::LEN_ONE;
      default: begin
        len   = itm_pkg::LEN_ONE;
        known = 1'b0;
      end
    endcase
    // equal to bytes, with the listed exceptions
    cycles = len;
    if (opcode == itm_pkg::OP_INC_DP) begin
      cycles = itm_pkg::LEN_TWO;
    end
    if (opcode == itm_pkg::OP_MUL || opcode == itm_pkg::OP_DIV) begin
      cycles = itm_pkg::CYC_FIVE;
    end
  end
endmodule

// ===== hdl/itm_core.sv
// instruction fetch and timing sequencer with small datapath
// assumes program memory answers in the same clock as PM_ADDR
// assumes jump/call opcodes are signalled by JUMP_HINT from outside
`timescale 1ns/10ps

// Notes on behaviour
// - machine cycle is four clocks
// - states C1 to C4 in fixed order
// - at most one program byte fetched per cycle
// - cycles equal bytes for most instructions
// - jumps and calls take one extra cycle
// - results and flags match standard family; only a few accumulator ops and the immediate add set ACC and carry here
// - add decode lengths and cycles
// - add with carry decode lengths
// - subtract with borrow decode lengths
// - increment; pointer increment two cycles
// - decrement decode lengths and cycles
// - multiply and divide take five cycles
// - accumulator single byte single cycle ops
// - logical and decode lengths
// - logical or decode lengths
// - exclusive or decode lengths
// - moves into accumulator decode lengths
// - moves from accumulator one cycle
// - moves into registers from immediate or direct two cycles
// - no-operation one cycle, only counter moves
module itm_core (
  input  wire logic        CLK,         // core clock, 50 MHz
  input  wire logic        SRST,        // synchronous reset, high
  input  wire logic [7:0]  PM_DATA,     // program memory byte
  input  wire logic        JUMP_HINT,   // current opcode is jump or call
  output      logic [15:0] PM_ADDR,     // program memory address
  output      logic        PM_FETCH,    // fetch strobe, C1 only
  output      logic        INSTR_DONE,  // pulses in the clock after an instruction's last
  output      logic [7:0]  OPCODE,      // opcode in execution
  output      logic [2:0]  INSTR_LEN,   // its byte length
  output      logic [2:0]  INSTR_CYC,   // its machine cycles
  output      logic [2:0]  MC_INDEX,    // machine cycle within instruction
  output      logic [7:0]  ACC_OUT,     // accumulator_reg value
  output      logic        CARRY_OUT    // carry flag
);
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  op;
    logic [2:0]  len;
    logic [2:0]  cyc;
    logic [2:0]  mc;
    logic [7:0]  operand;
    logic [7:0]  acc;
    logic        cy;
    logic        done;
    logic        jmp;
  } st_t;
  st_t state_reg;
  st_t state_next;

  itm_pkg::phase_t phase;
  logic            mc_end;
  logic [2:0]      dec_len;
  logic [2:0]      dec_cyc;
  logic            dec_known;
  logic            first_mc;
  logic            last_mc;
  logic [8:0]      sum9;

  ////////////////////////////////////////////////////////////////////////
  itm_phase u_phase (
    .clk    (CLK),
    .srst   (SRST),
    .phase  (phase),
    .mc_end (mc_end)
  );

  itm_decode u_decode (
    .opcode (PM_DATA),
    .len    (dec_len),
    .cycles (dec_cyc),
    .known  (dec_known)
  );

  ////////////////////////////////////////////////////////////////////////
  // instruction bounds; mc index 0 is the opcode cycle
  assign first_mc = (state_reg.mc == 3'h0);
  assign last_mc  = (state_reg.mc + 3'h1 >= state_reg.cyc);

  // accumulator adder for immediate add, carry taken per standard
  assign sum9 = {1'b0, state_reg.acc} + {1'b0, PM_DATA};

  ////////////////////////////////////////////////////////////////////////
  // sequencing: at most one fetch per machine cycle, in C1
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (phase == itm_pkg::ST_C1) begin
      if (first_mc) begin
        // opcode fetch: latch length and cycles from the decoder
        state_next.op  = PM_DATA;
        state_next.len = dec_len;
        state_next.cyc = dec_known ? dec_cyc : itm_pkg::LEN_ONE;
        // remembered so that checks on the finished instruction know it was a jump
        state_next.jmp = JUMP_HINT;
        if (JUMP_HINT) begin
          state_next.cyc = dec_cyc + itm_pkg::CYC_EXTRA_JUMP;
        end
        state_next.pc  = state_reg.pc + 16'h0001;
      end else if (state_reg.mc < {1'b0, state_reg.len[1:0]}) begin
        // operand byte; unused cycles fetch nothing
        state_next.operand = PM_DATA;
        state_next.pc      = state_reg.pc + 16'h0001;
      end
    end
    if (mc_end) begin
      if (last_mc && !(first_mc && JUMP_HINT)) begin
        state_next.mc   = 3'h0;
        state_next.done = 1'b1;
        // execute a few accumulator ops; others left to the datapath
        case (state_reg.op)
          itm_pkg::OP_CLR_A:    state_next.acc = 8'h00;
          itm_pkg::OP_MOV_A_IMM: state_next.acc = state_reg.operand;
          8'h04:                state_next.acc = state_reg.acc + 8'h01;
          8'h14:                state_next.acc = state_reg.acc - 8'h01;
          8'hF4:                state_next.acc = ~state_reg.acc;
          8'hC4:                state_next.acc = {state_reg.acc[3:0], state_reg.acc[7:4]};
          8'h23:                state_next.acc = {state_reg.acc[6:0], state_reg.acc[7]};
          8'h03:                state_next.acc = {state_reg.acc[0], state_reg.acc[7:1]};
          8'h33: begin
            state_next.acc = {state_reg.acc[6:0], state_reg.cy};
            state_next.cy  = state_reg.acc[7];
          end
          8'h13: begin
            state_next.acc = {state_reg.cy, state_reg.acc[7:1]};
            state_next.cy  = state_reg.acc[0];
          end
          default: state_next.acc = state_reg.acc;
        endcase
      end else begin
        state_next.mc = state_reg.mc + 3'h1;
      end
    end
    // immediate add resolved at the operand fetch
    if (phase == itm_pkg::ST_C1 && !first_mc && state_reg.op == 8'h24) begin
      state_next.acc = sum9[7:0];
      state_next.cy  = sum9[8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_reg.pc      <= 16'h0000;
      state_reg.op      <= itm_pkg::RESET_OPCODE;
      state_reg.len     <= itm_pkg::LEN_ONE;
      state_reg.cyc     <= itm_pkg::LEN_ONE;
      state_reg.mc      <= 3'h0;
      state_reg.operand <= 8'h00;
      state_reg.acc     <= 8'h00;
      state_reg.cy      <= 1'b0;
      state_reg.done    <= 1'b0;
      state_reg.jmp     <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign PM_ADDR    = state_reg.pc;
  assign PM_FETCH   = (phase == itm_pkg::ST_C1) && (first_mc || state_reg.mc < {1'b0, state_reg.len[1:0]});
  assign INSTR_DONE = state_reg.done;
  assign OPCODE     = state_reg.op;
  assign INSTR_LEN  = state_reg.len;
  assign INSTR_CYC  = state_reg.cyc;
  assign MC_INDEX   = state_reg.mc;
  assign ACC_OUT    = state_reg.acc;
  assign CARRY_OUT  = state_reg.cy;

  ////////////////////////////////////////////////////////////////////////
  chk_fetch_spacing: assert property (@(posedge CLK) disable iff (SRST)
    PM_FETCH |=> !PM_FETCH [*3])
    else $error("two fetches within one machine cycle");
  chk_fetch_phase: assert property (@(posedge CLK) disable iff (SRST)
    PM_FETCH |-> phase == itm_pkg::ST_C1)
    else $error("fetch outside first state");
  chk_nop_timing: assert property (@(posedge CLK) disable iff (SRST)
    (INSTR_DONE && !state_reg.jmp && OPCODE == itm_pkg::OP_NOP) |-> $stable(ACC_OUT) && INSTR_CYC == 3'h1)
    else $error("nop changed state or took more than one cycle");
  chk_muldiv_cycles: assert property (@(posedge CLK) disable iff (SRST)
    (INSTR_DONE && (OPCODE == itm_pkg::OP_MUL || OPCODE == itm_pkg::OP_DIV)) |-> INSTR_CYC == 3'h5)
    else $error("multiply or divide not five cycles");
  chk_incdp_cycles: assert property (@(posedge CLK) disable iff (SRST)
    (INSTR_DONE && OPCODE == itm_pkg::OP_INC_DP) |-> INSTR_CYC == 3'h2 && INSTR_LEN == 3'h1)
    else $error("pointer increment timing wrong");
  chk_cyc_eq_len: assert property (@(posedge CLK) disable iff (SRST)
    (INSTR_DONE && !state_reg.jmp && OPCODE != itm_pkg::OP_INC_DP && OPCODE != itm_pkg::OP_MUL
      && OPCODE != itm_pkg::OP_DIV) |-> INSTR_CYC == INSTR_LEN)
    else $error("cycles differ from bytes");
  chk_mov_ind_one: assert property (@(posedge CLK) disable iff (SRST)
    (INSTR_DONE && OPCODE == itm_pkg::OP_MOV_IND_A) |-> INSTR_LEN == 3'h1 && INSTR_CYC == 3'h1)
    else $error("move to indirect not one cycle");
  chk_done_spacing: assert property (@(posedge CLK) disable iff (SRST)
    INSTR_DONE |=> !INSTR_DONE [*3])
    else $error("instruction shorter than four clocks");
  chk_clr_acc: assert property (@(posedge CLK) disable iff (SRST)
    (INSTR_DONE && OPCODE == itm_pkg::OP_CLR_A) |-> ACC_OUT == 8'h00)
    else $error("clear left accumulator nonzero");
  chk_jump_extra: assert property (@(posedge CLK) disable iff (SRST)
    (INSTR_DONE && state_reg.jmp && OPCODE == itm_pkg::OP_NOP) |-> INSTR_CYC == 3'h2)
    else $error("jump did not take one extra cycle");
  cov_three_byte: cover property (@(posedge CLK) INSTR_DONE && INSTR_LEN == 3'h3);
  cov_mul: cover property (@(posedge CLK) INSTR_DONE && OPCODE == itm_pkg::OP_MUL);
  cov_jump: cover property (@(posedge CLK) INSTR_DONE && INSTR_CYC > INSTR_LEN);
endmodule

// ===== verification/itm_progmem.sv
// program memory model feeding the instruction timing core
// assumes the bench fills mem and hint before reset is released
`timescale 1ns/10ps
module itm_progmem (
  input  wire logic [15:0] addr,   // fetch address
  input  wire logic        fetch,  // fetch strobe from the core
  output      logic [7:0]  data,   // byte answered to the core
  output      logic        jump    // opcode at addr is a jump
);
  logic [7:0] mem  [0:1023];
  logic       hint [0:1023];
  logic [7:0] last;

  ////////////////////////////////////////////////////////////////
  // empty memory reads as no-operation, so running off the end is harmless
  initial begin
    last = 8'h5A;
    for (int i = 0; i < 1024; i++) begin
      mem[i]  = 8'h00;
      hint[i] = 1'b0;
    end
  end

  // remember the byte of the last fetch
  always @(posedge fetch) begin
    last <= mem[addr[9:0]];
  end

  // outside a fetch the bus shows the inverse of the last byte, so a late sample never passes by luck
  always_comb begin
    data = fetch ? mem[addr[9:0]] : ~last;
    jump = fetch & hint[addr[9:0]];
  end
endmodule

// ===== verification/testbench.sv
// self-checking bench for the instruction timing core
// assumes itm_core and itm_progmem are compiled; program built at time 1
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] OPS [79] = '{8'h00, 8'h28, 8'h2F, 8'h26, 8'h27, 8'h25, 8'h24, 8'h38, 8'h3F, 8'h36,
    8'h37, 8'h35, 8'h34, 8'h98, 8'h9F, 8'h96, 8'h97, 8'h95, 8'h94, 8'h04, 8'h08, 8'h0F, 8'h06, 8'h07, 8'h05,
    8'hA3, 8'h14, 8'h18, 8'h1F, 8'h16, 8'h17, 8'h15, 8'hA4, 8'h84, 8'hD4, 8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03,
    8'h13, 8'hC4, 8'h58, 8'h5F, 8'h56, 8'h57, 8'h55, 8'h54, 8'h52, 8'h53, 8'h48, 8'h4F, 8'h46, 8'h47, 8'h45,
    8'h44, 8'h42, 8'h43, 8'h68, 8'h6F, 8'h66, 8'h67, 8'h65, 8'h64, 8'h62, 8'h63, 8'hE8, 8'hEF, 8'hE6, 8'hE7,
    8'hE5, 8'h74, 8'hF8, 8'hFF, 8'hF6, 8'hA8, 8'hAF, 8'h78, 8'h7F};
  logic        CLK, SRST, JUMP_HINT, PM_FETCH, INSTR_DONE, CARRY_OUT;
  logic [7:0]  PM_DATA, OPCODE, ACC_OUT, acc;
  logic [15:0] PM_ADDR;
  logic [2:0]  INSTR_LEN, INSTR_CYC, MC_INDEX;
  logic [7:0]  ops [$], opd [$];
  logic [2:0]  lens [$], cycs [$];
  logic [15:0] pcs [$];
  logic [31:0] seed = 32'hEF39;
  logic        cy;
  int          n_mismatch = 0, total_checks = 0, idx, cnt, fcnt, wpc = 0;

  itm_core itm_core_i (.CLK(CLK), .SRST(SRST), .PM_DATA(PM_DATA), .JUMP_HINT(JUMP_HINT), .PM_ADDR(PM_ADDR),
    .PM_FETCH(PM_FETCH), .INSTR_DONE(INSTR_DONE), .OPCODE(OPCODE), .INSTR_LEN(INSTR_LEN),
    .INSTR_CYC(INSTR_CYC), .MC_INDEX(MC_INDEX), .ACC_OUT(ACC_OUT), .CARRY_OUT(CARRY_OUT));
  itm_progmem itm_progmem_i (.addr(PM_ADDR), .fetch(PM_FETCH), .data(PM_DATA), .jump(JUMP_HINT));

  ////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // expected {length, cycles}; anything not listed is one byte, one cycle
  function automatic logic [5:0] lc(input logic [7:0] op);
    if (op inside {8'h53, 8'h43, 8'h63}) return {3'h3, 3'h3};
    if (op inside {8'hA4, 8'h84}) return {3'h1, 3'h5};
    if (op == 8'hA3) return {3'h1, 3'h2};
    if (op inside {8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95, 8'h05, 8'h15, 8'h52, 8'h54, 8'h55, 8'h42, 8'h44,
      8'h45, 8'h62, 8'h64, 8'h65, 8'hE5, 8'h74, [8'h78:8'h7F], [8'hA8:8'hAF]}) return {3'h2, 3'h2};
    return {3'h1, 3'h1};
  endfunction

  // accumulator and carry effect of the executed operations
  task exec(input logic [7:0] op, input logic [7:0] imm);
    case (op)
      8'hE4: acc = 8'h00;
      8'hF4: acc = ~acc;
      8'h04: acc = acc + 8'h01;
      8'h14: acc = acc - 8'h01;
      8'h74: acc = imm;
      8'h24: {cy, acc} = {1'b0, acc} + {1'b0, imm};
      8'h23: acc = {acc[6:0], acc[7]};
      8'h33: {cy, acc} = {acc, cy};
      8'h03: acc = {acc[0], acc[7:1]};
      8'h13: {acc, cy} = {cy, acc};
      8'hC4: acc = {acc[3:0], acc[7:4]};
      default: ;
    endcase
  endtask

  // place one instruction with random operands and queue its expectations
  task add_instr(input logic [7:0] op, input logic jmp);
    logic [5:0] l;
    l = lc(op);
    seed = xs(seed);
    itm_progmem_i.mem[wpc] = op;
    itm_progmem_i.hint[wpc] = jmp;
    itm_progmem_i.mem[wpc + 1] = seed[7:0];
    itm_progmem_i.mem[wpc + 2] = seed[15:8];
    ops.push_back(op);
    opd.push_back(seed[7:0]);
    lens.push_back(l[5:3]);
    cycs.push_back(l[2:0] + {2'h0, jmp});
    wpc += int'(l[5:3]);
    pcs.push_back(16'(wpc));
  endtask

  task cmp_val(input logic [15:0] g, input logic [15:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  task cmp_cnt(input int g, input int e, input string m);
    total_checks++;
    if (g != e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask

  task do_reset;
    @(posedge CLK) SRST <= 1'b1;
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // per-instruction checks at the completion pulse, sampled on the falling edge where outputs are settled
  always @(negedge CLK) begin
    if (SRST) begin
      cnt = 0;
      fcnt = 0;
      idx = 0;
      acc = 8'h00;
      cy = 1'b0;
    end else if (INSTR_DONE === 1'b1 && idx < ops.size()) begin
      exec(ops[idx], opd[idx]);
      cmp_cnt(cnt, 4 * int'(cycs[idx]), "clocks");
      cmp_cnt(fcnt, int'(lens[idx]), "fetches");
      cmp_val(16'(OPCODE), 16'(ops[idx]), "opcode");
      cmp_val(16'(INSTR_LEN), 16'(lens[idx]), "length");
      cmp_val(16'(INSTR_CYC), 16'(cycs[idx]), "cycles");
      cmp_val(PM_ADDR, pcs[idx], "address");
      cmp_val(16'(MC_INDEX), 16'h0000, "cycle index");
      cmp_val({7'h00, CARRY_OUT, ACC_OUT}, {7'h00, cy, acc}, "accumulator");
      idx++;
      cnt = 1;
      fcnt = int'(PM_FETCH === 1'b1);
    end else begin
      cnt++;
      fcnt += int'(PM_FETCH === 1'b1);
    end
  end

  // every listed opcode once, a jump-hinted one, then random picks; a mid-run reset restarts it all
  initial begin
    SRST = 1'b1;
    #1;
    foreach (OPS[i]) add_instr(OPS[i], 1'b0);
    add_instr(8'h00, 1'b1);
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      add_instr(OPS[seed[15:8] % 79], 1'b0);
    end
    do_reset();
    repeat (37) @(posedge CLK);
    do_reset();
    $display("test mid-run reset done");
    for (int k = 0; k < 20000 && idx < ops.size(); k++) @(posedge CLK);
    if (idx < ops.size()) begin
      n_mismatch++;
      $display("MISMATCH t=%0t program did not complete", $time);
    end
    $display("test program of %0d instructions done", ops.size());
    report_and_stop();
  end
endmodule
